/* rtl/energy_and_band_monitor_regs.sv */
// register bank: energy snapshot, band comparator, start-up limit
// Notes on behaviour
// [R1] snapshot returned whole from one read
// [R2] upper field is 24-bit sample count
// [R3] sample count bytes seven, six, five
// [R4] wrap total counts accumulator wraps
// [R5] wrap total in bytes four, three
// [R6] accumulator in bytes two, one, zero
// [R7] snapshot read-only, zero at reset
// [R8] lower threshold rw, resets zero
// [R9] upper threshold rw, resets all ones
// [R10] comparator output available for pin
// [R11] status bit two is comparator level
// [R12] status bit one: above upper
// [R13] status bit zero: below lower
// [R14] status bit three: overcurrent warning
// [R15] status bits seven to four zero
// [R16] start-up limit only during turn-on
// [R17] limit code n gives (n+1)/16
// [R18] bits above code read zero
// [R19] comparator hysteresis: set, clear, hold
// [R20] sample adds and counts together
`timescale 1ns/100ps
`default_nettype none
module energy_and_band_monitor_regs #(
  parameter int CMP_W = 16
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  // register access from command layer
  input  wire energy_band_pkg::reg_req_s     req,
  output logic [63:0]                        rdata,
  output logic                               rvalid,
  output logic                               rerr,
  // measurement inputs
  input  wire logic                          sample_vld,
  input  wire logic [15:0]                   sample_power,
  input  wire logic                          cmp_vld,
  input  wire logic [CMP_W-1:0]              cmp_value,
  input  wire logic                          oc_warn_in,
  input  wire logic                          fet_turning_on,
  // outputs to pins and gate control
  output logic                               band_compare_pin,
  output logic                               startup_limit_active,
  output logic [4:0]                         startup_limit_sixteenths
);
  energy_band_pkg::energy_snapshot_s live;
  logic [15:0] band_low_reg;
  logic [15:0] band_high_reg;
  logic [3:0]  startup_code_reg;
  logic        output_overcurrent_warn_flag;
  logic        band_compare_out;
  logic        above_upper_flag;
  logic        below_lower_flag;
  logic [7:0]  status_byte;

  energy_meter u_meter (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .sample_vld   (sample_vld),
    .sample_power (sample_power),
    .live         (live)
  );

  band_comparator #(.W(CMP_W)) u_cmp (
    .clk_sys          (clk_sys),
    .rst_b            (rst_b),
    .value_vld        (cmp_vld),
    .value            (cmp_value),
    .low_thr          (band_low_reg),
    .high_thr         (band_high_reg),
    .band_compare_out (band_compare_out),
    .above_upper_flag (above_upper_flag),
    .below_lower_flag (below_lower_flag)
  );

  // [R14] warning flag follows monitor
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      output_overcurrent_warn_flag <= 1'b0;
    end else begin
      output_overcurrent_warn_flag <= oc_warn_in;
    end
  end

  // [R8] lower threshold write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      band_low_reg <= energy_band_pkg::BAND_LOW_RESET;
    end else if (req.wr && req.cmd == energy_band_pkg::CMD_BAND_LOW) begin
      band_low_reg <= req.wdata;
    end
  end

  // [R9] upper threshold write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      band_high_reg <= energy_band_pkg::BAND_HIGH_RESET;
    end else if (req.wr && req.cmd == energy_band_pkg::CMD_BAND_HIGH) begin
      band_high_reg <= req.wdata;
    end
  end

  // [R17] start-up code write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      startup_code_reg <= energy_band_pkg::STARTUP_LIMIT_RESET;
    end else if (req.wr && req.cmd == energy_band_pkg::CMD_STARTUP_LIMIT) begin
      startup_code_reg <= req.wdata[3:0];
    end
  end

  // [R16] limit applies only at turn-on
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      startup_limit_active     <= 1'b0;
      startup_limit_sixteenths <= 5'h10;
    end else begin
      startup_limit_active     <= fet_turning_on;
      // [R17] (n+1) sixteenths of full level
      startup_limit_sixteenths <= {1'b0, startup_code_reg} + 5'h01;
    end
  end

  // [R10] comparator level to pin
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      band_compare_pin <= 1'b0;
    end else begin
      band_compare_pin <= band_compare_out;
    end
  end

  always_comb begin
    status_byte = 8'h00;
    // [R15] upper bits stay zero
    // [R14] bit three overcurrent
    status_byte[energy_band_pkg::STATUS_OC_BIT]    = output_overcurrent_warn_flag;
    // [R11] bit two comparator level
    status_byte[energy_band_pkg::STATUS_OUT_BIT]   = band_compare_out;
    // [R12] bit one above upper
    status_byte[energy_band_pkg::STATUS_ABOVE_BIT] = above_upper_flag;
    // [R13] bit zero below lower
    status_byte[energy_band_pkg::STATUS_BELOW_BIT] = below_lower_flag;
  end

  // [R1] whole snapshot captured in one cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata  <= 64'h0000_0000_0000_0000;
      rvalid <= 1'b0;
      rerr   <= 1'b0;
    end else begin
      rvalid <= req.rd;
      rerr   <= 1'b0;
      if (req.rd) begin
        case (req.cmd)
          // [R3] [R5] [R6] byte placement by struct
          energy_band_pkg::CMD_ENERGY_SNAPSHOT: rdata <= live;
          energy_band_pkg::CMD_BAND_LOW:        rdata <= {48'h0000_0000_0000, band_low_reg};
          energy_band_pkg::CMD_BAND_HIGH:       rdata <= {48'h0000_0000_0000, band_high_reg};
          energy_band_pkg::CMD_BAND_STATUS:     rdata <= {56'h00_0000_0000_0000, status_byte};
          // [R18] upper bits zero
          energy_band_pkg::CMD_STARTUP_LIMIT:   rdata <= {60'h000_0000_0000_0000, startup_code_reg};
          default: begin
            rdata <= 64'h0000_0000_0000_0000;
            rerr  <= 1'b1;
          end
        endcase
      end
    end
  end

  // [R7] writes to the snapshot are ignored; state only from meter

  // ---- assertions
  property p_snapshot_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.rd && req.cmd == energy_band_pkg::CMD_ENERGY_SNAPSHOT) |=> rvalid && rdata == $past(live);
  endproperty
  a_snapshot_read: assert property (p_snapshot_read) else $error("snapshot read mismatch"); // [R1]

  property p_sample_count;
    @(posedge clk_sys) disable iff (!rst_b)
      sample_vld |=> live.sample_count == $past(live.sample_count) + 24'h00_0001;
  endproperty
  a_sample_count: assert property (p_sample_count) else $error("sample count not incremented"); // [R20]

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_b)
      !sample_vld |=> $stable(live.accum_wrap_total) && $stable(live.energy_accum_value);
  endproperty
  a_wrap: assert property (p_wrap) else $error("energy state moved without a sample"); // [R4]

  property p_status_top;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.rd && req.cmd == energy_band_pkg::CMD_BAND_STATUS) |=> rdata[63:4] == 60'h0;
  endproperty
  a_status_top: assert property (p_status_top) else $error("status reserved bits set"); // [R15]

  property p_cmp_high;
    @(posedge clk_sys) disable iff (!rst_b)
      (cmp_vld && cmp_value > band_high_reg) |=> band_compare_out ##1 band_compare_pin;
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("comparator not high above threshold"); // [R19]

  property p_cmp_low;
    @(posedge clk_sys) disable iff (!rst_b)
      (cmp_vld && cmp_value < band_low_reg && !(cmp_value > band_high_reg)) |=> !band_compare_out;
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("comparator not low below threshold"); // [R19]

  property p_limit;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.wr && req.cmd == energy_band_pkg::CMD_STARTUP_LIMIT) |=> ##1
        startup_limit_sixteenths == {1'b0, $past(req.wdata[3:0], 2)} + 5'h01;
  endproperty
  a_limit: assert property (p_limit) else $error("start-up limit scale wrong"); // [R17]

  property p_oc;
    @(posedge clk_sys) disable iff (!rst_b)
      oc_warn_in |=> status_byte[energy_band_pkg::STATUS_OC_BIT];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent bit missing"); // [R14]

  property p_active;
    @(posedge clk_sys) disable iff (!rst_b)
      !fet_turning_on |=> !startup_limit_active;
  endproperty
  a_active: assert property (p_active) else $error("limit active outside turn-on"); // [R16]

  c_snapshot: cover property (@(posedge clk_sys) disable iff (!rst_b)
    req.rd && req.cmd == energy_band_pkg::CMD_ENERGY_SNAPSHOT && live.accum_wrap_total != 16'h0000);
  c_cmp_rise: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(band_compare_out));
  c_cmp_fall: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(band_compare_out));
  c_bad_cmd:  cover property (@(posedge clk_sys) disable iff (!rst_b) rerr);
endmodule // energy_and_band_monitor_regs
`default_nettype wire

/* rtl/energy_band_pkg.sv */
// constants and carrier types for the energy and band monitor registers
package energy_band_pkg;
  localparam logic [7:0]  CMD_ENERGY_SNAPSHOT  = 8'h00_DC;
  localparam logic [7:0]  CMD_BAND_LOW         = 8'h00_F2;
  localparam logic [7:0]  CMD_BAND_HIGH        = 8'h00_F3;
  localparam logic [7:0]  CMD_BAND_STATUS      = 8'h00_F4;
  localparam logic [7:0]  CMD_STARTUP_LIMIT    = 8'h00_F6;
  localparam logic [15:0] BAND_LOW_RESET       = 16'h0000;
  localparam logic [15:0] BAND_HIGH_RESET      = 16'hFFFF;
  localparam logic [3:0]  STARTUP_LIMIT_RESET  = 4'hF;
  localparam logic [23:0] ENERGY_WRAP_MAX      = 24'h7F_FFFF;
  localparam int          SAMPLE_COUNT_W       = 24;
  localparam int          WRAP_TOTAL_W         = 16;
  localparam int          ENERGY_W             = 24;
  localparam int          STATUS_OC_BIT        = 3;
  localparam int          STATUS_OUT_BIT       = 2;
  localparam int          STATUS_ABOVE_BIT     = 1;
  localparam int          STATUS_BELOW_BIT     = 0;

  // snapshot image, msb first: byte 7 down to byte 0
  typedef struct packed {
    logic [23:0] sample_count;
    logic [15:0] accum_wrap_total;
    logic [23:0] energy_accum_value;
  } energy_snapshot_s;

  // register access request from the command layer
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } reg_req_s;
endpackage : energy_band_pkg

/* rtl/band_comparator.sv */
// hysteretic band comparator with above/below flags
`timescale 1ns/100ps
`default_nettype none
module band_comparator #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // compared value and thresholds
  input  wire logic         value_vld,
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] low_thr,
  input  wire logic [W-1:0] high_thr,
  // results
  output logic              band_compare_out,
  output logic              above_upper_flag,
  output logic              below_lower_flag
);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      above_upper_flag <= 1'b0;
      below_lower_flag <= 1'b0;
    end else if (value_vld) begin
      above_upper_flag <= value > high_thr;
      below_lower_flag <= value < low_thr;
    end
  end

  // [R19] set high, clear low, else hold
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      band_compare_out <= 1'b0;
    end else if (value_vld && value > high_thr) begin
      band_compare_out <= 1'b1;
    end else if (value_vld && value < low_thr) begin
      band_compare_out <= 1'b0;
    end
  end
endmodule // band_comparator
`default_nettype wire

/* rtl/energy_meter.sv */
// energy accumulator with sample count and wrap total
`timescale 1ns/100ps
`default_nettype none
module energy_meter (
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            rst_b,
  // input power samples
  input  wire logic                            sample_vld,
  input  wire logic [15:0]                     sample_power,
  // live state
  output energy_band_pkg::energy_snapshot_s    live
);
  logic [24:0] sum_next;

  always_comb begin
    sum_next = {1'b0, live.energy_accum_value} + {9'h0_00, sample_power};
  end

  // [R20] add and count together
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      live <= '0;
    end else if (sample_vld) begin
      live.sample_count <= live.sample_count + 24'h00_0001;
      // [R4] wrap past max counts
      if (sum_next > {1'b0, energy_band_pkg::ENERGY_WRAP_MAX}) begin
        live.energy_accum_value <= sum_next[23:0] - (energy_band_pkg::ENERGY_WRAP_MAX + 24'h00_0001);
        live.accum_wrap_total   <= live.accum_wrap_total + 16'h0001;
      end else begin
        live.energy_accum_value <= sum_next[23:0];
      end
    end
  end
endmodule // energy_meter
`default_nettype wire

/* dv/reg_host_model.sv */
// host model issuing register reads and writes
`timescale 1ns/100ps
`default_nettype none
module reg_host_model (
  // clock
  input  wire logic                  clk_sys,
  // request and answer
  output var energy_band_pkg::reg_req_s req,
  input  wire logic [63:0]           rdata,
  input  wire logic                  rvalid,
  input  wire logic                  rerr
);
  initial req = '0;
  task automatic write(input logic [7:0] c, input logic [15:0] w);
    @(posedge clk_sys);
    #1 req = '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: w};
    @(posedge clk_sys);
    #1 req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~w};
  endtask
  task automatic read(input logic [7:0] c, output logic [63:0] d, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1 req = '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 16'h0000};
    @(posedge clk_sys);
    #1 req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: 16'hffff};
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      #1 n++;
    end
    d = rdata;
    e = (rvalid === 1'b1) ? rerr : 1'bx;
  endtask
endmodule // reg_host_model
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the energy and band monitor registers
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                      clk_sys, rst_b, sample_vld, cmp_vld, oc_warn_in, fet_turning_on;
  logic [15:0]               sample_power, cmp_value, lo, hi, w, v;
  energy_band_pkg::reg_req_s req;
  logic [63:0]               rdata, d;
  logic                      rvalid, rerr, band_compare_pin, startup_limit_active, e;
  logic [4:0]                startup_limit_sixteenths;
  logic [23:0]               m_count, m_energy;
  logic [15:0]               m_wrap;
  logic                      m_lvl, m_above, m_below;
  int                        fails, checks_done, cycles, seed;

  energy_and_band_monitor_regs #(.CMP_W(16)) i_energy_and_band_monitor_regs (
    .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid), .rerr(rerr),
    .sample_vld(sample_vld), .sample_power(sample_power), .cmp_vld(cmp_vld), .cmp_value(cmp_value),
    .oc_warn_in(oc_warn_in), .fet_turning_on(fet_turning_on), .band_compare_pin(band_compare_pin),
    .startup_limit_active(startup_limit_active), .startup_limit_sixteenths(startup_limit_sixteenths));
  reg_host_model i_reg_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid), .rerr(rerr));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      report_and_stop;
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] c, input logic [63:0] exp);
    i_reg_host_model.read(c, d, e);
    chk(d, exp, "read data");
    chk({63'h0, e}, 64'h0, "read error flag");
  endtask

  task automatic feed(input logic [15:0] p);
    logic [24:0] s;
    s = {1'b0, m_energy} + {9'h000, p};
    m_count++;
    if (s > 25'h7f_ffff) begin
      m_energy = 24'(s - 25'h080_0000);
      m_wrap++;
    end else
      m_energy = s[23:0];
    @(posedge clk_sys);
    #1 sample_vld = 1'b1;
    sample_power = p;
  endtask

  task automatic cmp(input logic [15:0] x);
    if (x > hi) m_lvl = 1'b1;
    else if (x < lo) m_lvl = 1'b0;
    m_above = x > hi;
    m_below = x < lo;
    @(posedge clk_sys);
    #1 cmp_vld = 1'b1;
    cmp_value = x;
    @(posedge clk_sys);
    #1 cmp_vld = 1'b0;
    @(posedge clk_sys);
    #1 chk({63'h0, band_compare_pin}, {63'h0, m_lvl}, "pin level");
    rd_chk(energy_band_pkg::CMD_BAND_STATUS, {60'h0, oc_warn_in, m_lvl, m_above, m_below});
  endtask

  initial begin
    seed = 32'hf48324a5;
    {rst_b, sample_vld, cmp_vld, oc_warn_in, fet_turning_on, m_lvl} = '0;
    {sample_power, cmp_value, m_count, m_energy, m_wrap} = '0;
    {fails, checks_done, cycles} = '0;
    lo = 16'h0000;
    hi = 16'hffff;
    repeat (16) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    rd_chk(energy_band_pkg::CMD_BAND_LOW, 64'h0);
    rd_chk(energy_band_pkg::CMD_BAND_HIGH, 64'hffff);
    rd_chk(energy_band_pkg::CMD_BAND_STATUS, 64'h0);
    rd_chk(energy_band_pkg::CMD_STARTUP_LIMIT, 64'hf);
    rd_chk(energy_band_pkg::CMD_ENERGY_SNAPSHOT, 64'h0);
    chk({59'h0, startup_limit_sixteenths}, 64'h10, "reset sixteenths");
    $display("test reset values done");
    i_reg_host_model.read(8'hf5, d, e);
    chk(d, 64'h0, "unmapped data");
    chk({63'h0, e}, 64'h1, "unmapped error flag");
    i_reg_host_model.write(energy_band_pkg::CMD_ENERGY_SNAPSHOT, 16'h1234);
    rd_chk(energy_band_pkg::CMD_ENERGY_SNAPSHOT, 64'h0);
    for (int n = 0; n < 16; n++) begin
      w = 16'($random(seed));
      w[3:0] = n[3:0];
      i_reg_host_model.write(energy_band_pkg::CMD_STARTUP_LIMIT, w);
      rd_chk(energy_band_pkg::CMD_STARTUP_LIMIT, {60'h0, w[3:0]});
      chk({59'h0, startup_limit_sixteenths}, 64'(n + 1), "sixteenths");
    end
    fet_turning_on = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({63'h0, startup_limit_active}, 64'h1, "limit active");
    fet_turning_on = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({63'h0, startup_limit_active}, 64'h0, "limit idle");
    $display("test start-up limit done");
    for (int n = 0; n < 180; n++)
      feed(n < 140 ? 16'hffff : 16'($random(seed)));
    @(posedge clk_sys);
    #1 sample_vld = 1'b0;
    rd_chk(energy_band_pkg::CMD_ENERGY_SNAPSHOT, {m_count, m_wrap, m_energy});
    $display("test energy snapshot done");
    lo = 16'h1000 + 16'($random(seed) & 32'h0fff);
    hi = 16'h8000 + 16'($random(seed) & 32'h0fff);
    i_reg_host_model.write(energy_band_pkg::CMD_BAND_LOW, lo);
    i_reg_host_model.write(energy_band_pkg::CMD_BAND_HIGH, hi);
    rd_chk(energy_band_pkg::CMD_BAND_LOW, {48'h0, lo});
    rd_chk(energy_band_pkg::CMD_BAND_HIGH, {48'h0, hi});
    cmp(16'hffff);
    cmp(16'h4000);
    cmp(16'h0000);
    cmp(16'h4000);
    for (int n = 0; n < 30; n++) begin
      v = 16'($random(seed));
      if (v == lo || v == hi) v++;
      oc_warn_in = 1'($random(seed));
      cmp(v);
    end
    $display("test band comparator done");
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
